//--- hw/hpg_external_memory_unit_route.sv
// Maps external memory cycles onto the port pins they take over
`timescale 1ns/1ns
module hpg_xmem_route (
   input wire logic xmem_on,
   input wire logic xmem_muxed,
   input wire logic xmem_addr_phase,
   input wire logic xmem_read,
   input wire logic [15:0] xmem_addr,
   input wire hpg_pkg::hpg_byte_t xmem_wdata,
   hpg_port_if.ctrl port_b,
   hpg_port_if.ctrl port_c,
   hpg_port_if.ctrl port_d
);
   import hpg_pkg::*;

   always_comb begin
      // Port b carries the high address only without multiplexing
      port_b.xmem_own = {PORT_W{xmem_on & ~xmem_muxed}}; // RQ5
      port_b.xmem_val = xmem_addr[15:8]; // RQ5
      port_b.xmem_hiz = 1'b0;

      port_c.xmem_own = {PORT_W{xmem_on}}; // RQ6
      port_c.xmem_val = xmem_muxed ? xmem_addr[15:8] : xmem_addr[7:0]; // RQ6
      port_c.xmem_hiz = 1'b0;

      port_d.xmem_own = {PORT_W{xmem_on}}; // RQ7
      if (xmem_muxed && xmem_addr_phase) begin
         port_d.xmem_val = xmem_addr[7:0]; // RQ7
         port_d.xmem_hiz = 1'b0;
      end else begin
         port_d.xmem_val = xmem_wdata; // RQ7
         // Reads release the data bus so the memory can drive it
         port_d.xmem_hiz = xmem_read; // RQ11
      end
   end
endmodule

//--- hw/hpg_high_ports.sv
// Upper port group: drive-mode and latch registers, read-back and pin drive
// Notes on behaviour
// (RQ1) Drive-mode bit 0 selects open-drain, 1 selects push-pull.
// (RQ2) Latch value appears on pins; latch bit 0 always drives low.
// (RQ3) Latch bit 1 drives high only in push-pull; otherwise the pin floats.
// (RQ4) Reading a port data register returns pin levels, not the latch.
// (RQ5) Non-multiplexed external memory drives port b as address high byte.
// (RQ6) External memory drives port c: high address muxed, low address otherwise.
// (RQ7) External memory drives port d: address/data muxed, data otherwise.
// (RQ8) I2C lines and mode-0 UART receive pins are forced open-drain.
// (RQ9) Read-modify-write read phase returns latch contents instead of pins.
// (RQ10) After reset every pin is in open-drain mode.
// (RQ11) Off-chip access overrides latch values; reads float the data bus.
// (RQ12) Pull-up on by default, off when driving low or globally disabled.
// (RQ13) Output enabled when latch is 0, or latch 1 in push-pull.
`timescale 1ns/1ns
module hpg_high_ports (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic sfr_page_sel,
   input wire hpg_pkg::hpg_byte_t sfr_addr,
   input wire logic sfr_wr,
   input wire hpg_pkg::hpg_byte_t sfr_wdata,
   input wire logic sfr_rd,
   input wire logic sfr_rmw,
   output logic [hpg_pkg::PORT_W-1:0] sfr_rdata,
   output logic sfr_rd_ack,
   input wire hpg_pkg::hpg_byte_t port_a_latch,
   input wire hpg_pkg::hpg_byte_t port_b_pin_in,
   input wire hpg_pkg::hpg_byte_t port_c_pin_in,
   input wire hpg_pkg::hpg_byte_t port_d_pin_in,
   input wire hpg_pkg::hpg_byte_t port_a_force_od,
   input wire hpg_pkg::hpg_byte_t port_b_force_od,
   input wire hpg_pkg::hpg_byte_t port_c_force_od,
   input wire hpg_pkg::hpg_byte_t port_d_force_od,
   input wire logic global_pullup_disable,
   input wire logic xmem_active,
   input wire logic xmem_high_sel,
   input wire logic xmem_muxed,
   input wire logic xmem_addr_phase,
   input wire logic xmem_read,
   input wire logic [15:0] xmem_addr,
   input wire hpg_pkg::hpg_byte_t xmem_wdata,
   output logic [hpg_pkg::PORT_W-1:0] port_a_out,
   output logic [hpg_pkg::PORT_W-1:0] port_a_oe,
   output logic [hpg_pkg::PORT_W-1:0] port_a_pullup_en,
   output logic [hpg_pkg::PORT_W-1:0] port_b_out,
   output logic [hpg_pkg::PORT_W-1:0] port_b_oe,
   output logic [hpg_pkg::PORT_W-1:0] port_b_pullup_en,
   output logic [hpg_pkg::PORT_W-1:0] port_c_out,
   output logic [hpg_pkg::PORT_W-1:0] port_c_oe,
   output logic [hpg_pkg::PORT_W-1:0] port_c_pullup_en,
   output logic [hpg_pkg::PORT_W-1:0] port_d_out,
   output logic [hpg_pkg::PORT_W-1:0] port_d_oe,
   output logic [hpg_pkg::PORT_W-1:0] port_d_pullup_en
);
   import hpg_pkg::*;

   hpg_regs_s regs_reg;
   hpg_regs_s regs_next;
   logic wr_hit;
   logic rd_hit;
   logic xmem_on;

   hpg_port_if if_a ();
   hpg_port_if if_b ();
   hpg_port_if if_c ();
   hpg_port_if if_d ();

   // Registers live only on the port page; other pages never alias them
   assign wr_hit = sfr_wr & sfr_page_sel;
   assign rd_hit = sfr_rd & sfr_page_sel;
   assign xmem_on = xmem_active & xmem_high_sel;

   always_comb begin
      regs_next = regs_reg;
      regs_next.rd_ack = sfr_rd;
      if (wr_hit) begin
         unique case (sfr_addr)
            ADDR_A_MODE: begin
               regs_next.mode_a = sfr_wdata; // RQ1
            end
            ADDR_B_MODE: begin
               regs_next.mode_b = sfr_wdata; // RQ1
            end
            ADDR_C_MODE: begin
               regs_next.mode_c = sfr_wdata; // RQ1
            end
            ADDR_D_MODE: begin
               regs_next.mode_d = sfr_wdata; // RQ1
            end
            ADDR_B_LATCH: begin
               regs_next.latch_b = sfr_wdata; // RQ2
            end
            ADDR_C_LATCH: begin
               regs_next.latch_c = sfr_wdata; // RQ2
            end
            ADDR_D_LATCH: begin
               regs_next.latch_d = sfr_wdata; // RQ2
            end
            default: begin
               regs_next.rdata = regs_reg.rdata;
            end
         endcase
      end
      if (rd_hit) begin
         unique case (sfr_addr)
            ADDR_A_MODE: begin
               regs_next.rdata = regs_reg.mode_a;
            end
            ADDR_B_MODE: begin
               regs_next.rdata = regs_reg.mode_b;
            end
            ADDR_C_MODE: begin
               regs_next.rdata = regs_reg.mode_c;
            end
            ADDR_D_MODE: begin
               regs_next.rdata = regs_reg.mode_d;
            end
            // Modify phase must not copy in a level an outside load holds
            ADDR_B_LATCH: begin
               regs_next.rdata = sfr_rmw ? regs_reg.latch_b : port_b_pin_in; // RQ4 RQ9
            end
            ADDR_C_LATCH: begin
               regs_next.rdata = sfr_rmw ? regs_reg.latch_c : port_c_pin_in; // RQ4 RQ9
            end
            ADDR_D_LATCH: begin
               regs_next.rdata = sfr_rmw ? regs_reg.latch_d : port_d_pin_in; // RQ4 RQ9
            end
            default: begin
               regs_next.rdata = RST_RDATA;
            end
         endcase
      end else if (sfr_rd) begin
         regs_next.rdata = RST_RDATA;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         regs_reg <= '{mode_a: RST_MODE, mode_b: RST_MODE, mode_c: RST_MODE, // RQ10
            mode_d: RST_MODE, latch_b: RST_LATCH, latch_c: RST_LATCH,
            latch_d: RST_LATCH, rdata: RST_RDATA, rd_ack: 1'b0};
      end else begin
         regs_reg <= regs_next;
      end
   end

   // Port a latch sits elsewhere; only its drive shaping is done here
   always_comb begin
      if_a.latch = port_a_latch;
      if_a.mode = regs_reg.mode_a;
      if_a.force_od = port_a_force_od; // RQ8
      if_a.xmem_own = '0;
      if_a.xmem_val = '0;
      if_a.xmem_hiz = 1'b0;
      if_a.pullup_dis = global_pullup_disable; // RQ12

      if_b.latch = regs_reg.latch_b;
      if_b.mode = regs_reg.mode_b;
      if_b.force_od = port_b_force_od; // RQ8
      if_b.pullup_dis = global_pullup_disable; // RQ12

      if_c.latch = regs_reg.latch_c;
      if_c.mode = regs_reg.mode_c;
      if_c.force_od = port_c_force_od; // RQ8
      if_c.pullup_dis = global_pullup_disable; // RQ12

      if_d.latch = regs_reg.latch_d;
      if_d.mode = regs_reg.mode_d;
      if_d.force_od = port_d_force_od; // RQ8
      if_d.pullup_dis = global_pullup_disable; // RQ12
   end

   hpg_xmem_route u_route (
      .xmem_on(xmem_on),
      .xmem_muxed(xmem_muxed),
      .xmem_addr_phase(xmem_addr_phase),
      .xmem_read(xmem_read),
      .xmem_addr(xmem_addr),
      .xmem_wdata(xmem_wdata),
      .port_b(if_b.ctrl),
      .port_c(if_c.ctrl),
      .port_d(if_d.ctrl)
   );

   hpg_port_pins u_pins_a (
      .clk(clk),
      .rst_n(rst_n),
      .port(if_a.pins)
   );
   hpg_port_pins u_pins_b (
      .clk(clk),
      .rst_n(rst_n),
      .port(if_b.pins)
   );
   hpg_port_pins u_pins_c (
      .clk(clk),
      .rst_n(rst_n),
      .port(if_c.pins)
   );
   hpg_port_pins u_pins_d (
      .clk(clk),
      .rst_n(rst_n),
      .port(if_d.pins)
   );

   // All pin outputs come from the driver flip-flops
   assign port_a_out = if_a.drv_out;
   assign port_a_oe = if_a.drv_oe;
   assign port_a_pullup_en = if_a.pull_en;
   assign port_b_out = if_b.drv_out;
   assign port_b_oe = if_b.drv_oe;
   assign port_b_pullup_en = if_b.pull_en;
   assign port_c_out = if_c.drv_out;
   assign port_c_oe = if_c.drv_oe;
   assign port_c_pullup_en = if_c.pull_en;
   assign port_d_out = if_d.drv_out;
   assign port_d_oe = if_d.drv_oe;
   assign port_d_pullup_en = if_d.pull_en;
   assign sfr_rdata = regs_reg.rdata;
   assign sfr_rd_ack = regs_reg.rd_ack;
endmodule

//--- hw/hpg_port_pins.sv
// Registered pin driver for one byte-wide port
`timescale 1ns/1ns
module hpg_port_pins (
   input wire logic clk,
   input wire logic rst_n,
   hpg_port_if.pins port
);
   import hpg_pkg::*;

   hpg_pins_s state_reg;
   hpg_pins_s state_next;

   always_comb begin
      logic val;
      logic push_pull;
      logic oe;
      val = 1'b0;
      push_pull = 1'b0;
      oe = 1'b0;
      state_next = state_reg;
      for (int i = 0; i < PORT_W; i++) begin
         // Memory interface owns the value, never the drive mode
         val = port.xmem_own[i] ? port.xmem_val[i] : port.latch[i]; // RQ11
         // Serial lines stay open-drain whatever the mode bit says
         push_pull = port.mode[i] & ~port.force_od[i]; // RQ1 RQ8
         oe = ~val | push_pull; // RQ2 RQ3 RQ13
         if (port.xmem_own[i] && port.xmem_hiz) begin
            oe = 1'b0; // RQ11
         end
         state_next.drv_out[i] = val;
         state_next.drv_oe[i] = oe;
         // A pin pulling low must not fight its own pull-up
         state_next.pull_en[i] = ~port.pullup_dis & ~(oe & ~val); // RQ12
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= '{drv_out: RST_DRV_OUT, drv_oe: RST_DRV_OE, pull_en: RST_PULL_EN};
      end else begin
         state_reg <= state_next;
      end
   end

   assign port.drv_out = state_reg.drv_out;
   assign port.drv_oe = state_reg.drv_oe;
   assign port.pull_en = state_reg.pull_en;
endmodule

//--- pkg/hpg_pkg.sv
// Constants and state types for the upper port group I/O block
package hpg_pkg;
   localparam int PORT_W = 8;
   typedef logic [PORT_W-1:0] hpg_byte_t;

   // Special function register addresses, all on the port page
   localparam hpg_byte_t ADDR_A_MODE = 8'h9c;
   localparam hpg_byte_t ADDR_B_MODE = 8'h9d;
   localparam hpg_byte_t ADDR_C_MODE = 8'h9e;
   localparam hpg_byte_t ADDR_D_MODE = 8'h9f;
   localparam hpg_byte_t ADDR_B_LATCH = 8'hd8;
   localparam hpg_byte_t ADDR_C_LATCH = 8'he8;
   localparam hpg_byte_t ADDR_D_LATCH = 8'hf8;

   // Values after reset
   localparam hpg_byte_t RST_MODE = 8'h00;
   localparam hpg_byte_t RST_LATCH = 8'hff;
   localparam hpg_byte_t RST_RDATA = 8'h00;
   localparam hpg_byte_t RST_DRV_OUT = 8'hff;
   localparam hpg_byte_t RST_DRV_OE = 8'h00;
   localparam hpg_byte_t RST_PULL_EN = 8'hff;

   typedef struct packed {
      hpg_byte_t mode_a;
      hpg_byte_t mode_b;
      hpg_byte_t mode_c;
      hpg_byte_t mode_d;
      hpg_byte_t latch_b;
      hpg_byte_t latch_c;
      hpg_byte_t latch_d;
      hpg_byte_t rdata;
      logic rd_ack;
   } hpg_regs_s;

   typedef struct packed {
      hpg_byte_t drv_out;
      hpg_byte_t drv_oe;
      hpg_byte_t pull_en;
   } hpg_pins_s;
endpackage

//--- pkg/hpg_port_if.sv
// Carrier between the register logic and one port's pin driver
`timescale 1ns/1ns
interface hpg_port_if;
   import hpg_pkg::*;
   hpg_byte_t latch;
   hpg_byte_t mode;
   hpg_byte_t force_od;
   hpg_byte_t xmem_own;
   hpg_byte_t xmem_val;
   logic xmem_hiz;
   logic pullup_dis;
   hpg_byte_t drv_out;
   hpg_byte_t drv_oe;
   hpg_byte_t pull_en;

   modport ctrl (
      output latch, mode, force_od, xmem_own, xmem_val, xmem_hiz, pullup_dis,
      input drv_out, drv_oe, pull_en
   );
   modport pins (
      input latch, mode, force_od, xmem_own, xmem_val, xmem_hiz, pullup_dis,
      output drv_out, drv_oe, pull_en
   );
endinterface

//--- test/hpg_board_tb.sv
// Board model of one port: external sources, pull-ups and bare lines
`timescale 1ns/1ns
module hpg_board_tb (
   input wire logic clk,
   input wire hpg_pkg::hpg_byte_t out,
   input wire hpg_pkg::hpg_byte_t oe,
   input wire hpg_pkg::hpg_byte_t pull,
   input wire hpg_pkg::hpg_byte_t ext_val,
   input wire hpg_pkg::hpg_byte_t ext_en,
   output hpg_pkg::hpg_byte_t pin_in
);
   import hpg_pkg::*;
   hpg_byte_t toggle = 8'h5a;
   hpg_byte_t src;
   // External source beats the weak pull-up; bare lines toggle so no stale level passes
   assign src = (ext_en & ext_val) | (~ext_en & (pull | toggle));
   always @(posedge clk) begin
      toggle <= ~toggle;
      pin_in <= (oe & out) | (~oe & src);
   end
endmodule

//--- test/hpg_high_ports_props.sv
// Assertions on the upper port group top-level ports
`timescale 1ns/1ns
module hpg_high_ports_props (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic sfr_rd,
   input wire logic sfr_rd_ack,
   input wire hpg_pkg::hpg_byte_t port_d_force_od,
   input wire logic global_pullup_disable,
   input wire logic xmem_active,
   input wire logic xmem_high_sel,
   input wire logic xmem_muxed,
   input wire logic xmem_addr_phase,
   input wire logic xmem_read,
   input wire logic [15:0] xmem_addr,
   input wire hpg_pkg::hpg_byte_t port_b_out,
   input wire hpg_pkg::hpg_byte_t port_b_oe,
   input wire hpg_pkg::hpg_byte_t port_b_pullup_en,
   input wire hpg_pkg::hpg_byte_t port_d_out,
   input wire hpg_pkg::hpg_byte_t port_d_oe,
   input wire hpg_pkg::hpg_byte_t port_d_pullup_en
);
   import hpg_pkg::*;
   logic on;
   assign on = xmem_active & xmem_high_sel;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_low_on; (port_b_oe | port_b_out) == 8'hff; endproperty
   a_low_on: assert property (p_low_on) else $error("low pin not driven");
   property p_od_forced; (port_d_out & port_d_oe & $past(port_d_force_od)) == 8'h00; endproperty
   a_od_forced: assert property (p_od_forced) else $error("forced pin driven high");
   property p_pull_low; (port_d_pullup_en & port_d_oe & ~port_d_out) == 8'h00; endproperty
   a_pull_low: assert property (p_pull_low) else $error("pull-up on a low pin");
   property p_pull_off; global_pullup_disable |=> port_b_pullup_en == 8'h00; endproperty
   a_pull_off: assert property (p_pull_off) else $error("pull-up not disabled");
   property p_rd_ack; 1'b1 |=> sfr_rd_ack == $past(sfr_rd); endproperty
   a_rd_ack: assert property (p_rd_ack) else $error("read ack mistimed");
   property p_xmem_b; on && !xmem_muxed |=> port_b_out == $past(xmem_addr[15:8]); endproperty
   a_xmem_b: assert property (p_xmem_b) else $error("port b not high address");
   property p_xmem_rd;
      on && xmem_read && !(xmem_muxed && xmem_addr_phase) |=> port_d_oe == 8'h00;
   endproperty
   a_xmem_rd: assert property (p_xmem_rd) else $error("data bus driven on read");
   property p_xmem_ad;
      on && xmem_muxed && xmem_addr_phase |=> port_d_out == $past(xmem_addr[7:0]);
   endproperty
   a_xmem_ad: assert property (p_xmem_ad) else $error("port d not low address");
endmodule
bind hpg_high_ports hpg_high_ports_props props_u (.clk, .rst_n, .sfr_rd, .sfr_rd_ack,
   .port_d_force_od, .global_pullup_disable, .xmem_active, .xmem_high_sel, .xmem_muxed,
   .xmem_addr_phase, .xmem_read, .xmem_addr, .port_b_out, .port_b_oe, .port_b_pullup_en,
   .port_d_out, .port_d_oe, .port_d_pullup_en);

//--- test/test_high_port_group_io.sv
// Random and corner-case bench for the upper port group block
`timescale 1ns/1ns
module test_high_port_group_io;
   import hpg_pkg::*;
   logic clk = 0, rst_n = 0, sel = 0, wr = 0, rd = 0, rmw = 0, dis = 0;
   logic ea = 0, hs = 0, mx = 0, ph = 0, er = 0, ack;
   logic [15:0] ead = 0;
   hpg_byte_t addr = 0, wd = 0, ew = 0, rdata;
   hpg_byte_t po[4], pe[4], pp[4], pin[3];
   hpg_byte_t v[4] = '{default: 0}, m[4] = '{default: 0}, f[4] = '{default: 0};
   hpg_byte_t xv[3] = '{default: 0}, xe[3] = '{default: 0};
   hpg_byte_t ma[4] = '{ADDR_B_MODE, ADDR_C_MODE, ADDR_D_MODE, ADDR_A_MODE};
   hpg_byte_t la[3] = '{ADDR_B_LATCH, ADDR_C_LATCH, ADDR_D_LATCH};
   int n_mismatch = 0, comparisons = 0, seed = 32'h5e38159c;
   always #2 clk = ~clk;
   hpg_high_ports dut_u (.clk(clk), .rst_n(rst_n), .sfr_page_sel(sel), .sfr_addr(addr),
      .sfr_wr(wr), .sfr_wdata(wd), .sfr_rd(rd), .sfr_rmw(rmw), .sfr_rdata(rdata),
      .sfr_rd_ack(ack), .port_a_latch(v[3]), .port_b_pin_in(pin[0]), .port_c_pin_in(pin[1]),
      .port_d_pin_in(pin[2]), .port_a_force_od(f[3]), .port_b_force_od(f[0]),
      .port_c_force_od(f[1]), .port_d_force_od(f[2]), .global_pullup_disable(dis),
      .xmem_active(ea), .xmem_high_sel(hs), .xmem_muxed(mx), .xmem_addr_phase(ph),
      .xmem_read(er), .xmem_addr(ead), .xmem_wdata(ew), .port_a_out(po[3]), .port_a_oe(pe[3]),
      .port_a_pullup_en(pp[3]), .port_b_out(po[0]), .port_b_oe(pe[0]), .port_b_pullup_en(pp[0]),
      .port_c_out(po[1]), .port_c_oe(pe[1]), .port_c_pullup_en(pp[1]), .port_d_out(po[2]),
      .port_d_oe(pe[2]), .port_d_pullup_en(pp[2]));
   for (genvar i = 0; i < 3; i++) begin : g_board
      hpg_board_tb brd_u (.clk(clk), .out(po[i]), .oe(pe[i]), .pull(pp[i]), .ext_val(xv[i]),
         .ext_en(xe[i]), .pin_in(pin[i]));
   end
   function automatic hpg_byte_t rnd();
      return 8'($random(seed));
   endfunction
   function automatic hpg_byte_t val_f(int i);
      if (i == 0 && ea && hs && !mx) return ead[15:8];
      if (i == 1 && ea && hs) return mx ? ead[15:8] : ead[7:0];
      if (i == 2 && ea && hs) return (mx && ph) ? ead[7:0] : ew;
      return v[i];
   endfunction
   function automatic hpg_byte_t oe_f(int i);
      if (i == 2 && ea && hs && er && !(mx && ph)) return 8'h00;
      return ~val_f(i) | (m[i] & ~f[i]);
   endfunction
   task automatic chk(input hpg_byte_t got, exp, input string s);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("FAIL %0t %s got %h exp %h", $time, s, got, exp);
      end
   endtask
   task automatic wr_reg(input hpg_byte_t a, d);
      @(negedge clk) {wr, addr, wd} = {1'b1, a, d};
      @(negedge clk) wr = 0;
   endtask
   task automatic rd_chk(input hpg_byte_t a, input logic r, input hpg_byte_t e, input string s);
      @(negedge clk) {rd, rmw, addr} = {1'b1, r, a};
      @(negedge clk) rd = 0;
      chk(8'(ack), 8'h01, "read ack");
      chk(rdata, e, s);
   endtask
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (16) @(negedge clk);
      rst_n = 1;
      sel = 1;
      for (int i = 0; i < 3; i++) begin
         chk(pe[i], 8'h00, "reset oe");
         rd_chk(ma[i], 0, 8'h00, "reset mode");
         rd_chk(la[i], 1, 8'hff, "reset latch");
      end
      $display("test reset done");
      for (int k = 0; k < 40; k++) begin
         xe = '{default: 0};
         for (int i = 0; i < 4; i++) begin
            m[i] = rnd();
            wr_reg(ma[i], m[i]);
            v[i] = rnd();
            if (i < 3) wr_reg(la[i], v[i]);
         end
         {ea, hs, mx, ph, er, dis} = 6'(rnd());
         // First passes walk every memory-cycle shape with the interface owning the pins
         if (k < 8) {ea, hs, mx, ph, er} = {2'b11, 3'(k)};
         ead = {rnd(), rnd()};
         ew = rnd();
         foreach (f[i]) f[i] = rnd();
         // Board drives only undriven lines, so a plain read shows pins and an RMW read shows the latch
         foreach (xe[i]) begin
            xe[i] = ~oe_f(i);
            xv[i] = rnd();
         end
         repeat (3) @(negedge clk);
         foreach (po[i]) begin
            chk(po[i], val_f(i), "pin value");
            chk(pe[i], oe_f(i), "pin enable");
            chk(pp[i], dis ? 8'h00 : ~(oe_f(i) & ~val_f(i)), "pull-up");
            rd_chk(ma[i], 0, m[i], "mode read");
         end
         foreach (pin[i]) begin
            rd_chk(la[i], 0, (oe_f(i) & val_f(i)) | (~oe_f(i) & xv[i]), "pin read");
            rd_chk(la[i], 1, v[i], "latch read");
         end
      end
      $display("test random done");
      sel = 0;
      wr_reg(ADDR_B_LATCH, ~v[0]);
      rd_chk(ADDR_B_MODE, 0, 8'h00, "off page read");
      sel = 1;
      rd_chk(ADDR_B_LATCH, 1, v[0], "off page write");
      rd_chk(8'hc8, 0, 8'h00, "unmapped read");
      $display("test refused done");
      rst_n = 0;
      @(negedge clk);
      chk(pe[2], 8'h00, "second reset oe");
      rst_n = 1;
      rd_chk(ADDR_D_LATCH, 1, 8'hff, "second reset latch");
      rd_chk(ADDR_D_MODE, 0, 8'h00, "second reset mode");
      $display("test second reset done");
      summarize();
   end
   initial begin
      #100000;
      n_mismatch++;
      summarize();
   end
endmodule
